//--- stac_timer.sv
// Sixteen-bit timer core with byte-wide register access
`timescale 1ns/10ps
module stac_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // CPU I/O bus
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Pins and capture sources
  input wire logic external_count_pin,
  input wire logic capture_pin,
  input wire logic analog_cmp_out,
  input wire logic capture_src_cmp,
  // Shared prescaler for the 8-bit timer
  output logic [3:0] presc_taps,
  output logic presc_clear,
  // Interrupt requests
  output logic irq_overflow,
  output logic irq_match_a,
  output logic irq_match_b,
  output logic irq_capture,
  // Counter status for the waveform generator
  output logic timer_tick,
  output logic match_a,
  output logic match_b,
  output logic at_bottom,
  output logic at_max,
  output logic at_top,
  output logic compare_output_a,
  output logic compare_output_b
);
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] hold;
    logic [15:0] cnt;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpa;
    logic [15:0] cmpb_buf;
    logic [15:0] cmpb;
    logic [15:0] cap;
    logic [3:0] flags;
    logic [3:0] mask;
    logic psr;
    logic [1:0] pin_sync;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [stac_pkg::FILT_LEN-1:0] filt;
    logic filt_lvl;
    logic [7:0] rdata;
  } stac_state_t;

  stac_state_t s_reg;
  stac_state_t s_next;
  logic [3:0] mode;
  logic [15:0] top_val;
  logic a_is_top;
  logic wrap;
  logic cap_src;
  logic cap_event;
  logic filt_new;

  // Modes that reload compare values at the top of the count
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hc || m == 4'hd);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m,
    input logic [15:0] ca, input logic [15:0] ic);
    unique case (m)
      4'h1, 4'h5: top_of = stac_pkg::TOP_8BIT;
      4'h2, 4'h6: top_of = stac_pkg::TOP_9BIT;
      4'h3, 4'h7: top_of = stac_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_of = ca;
      4'h8, 4'ha, 4'hc, 4'he: top_of = ic;
      default: top_of = stac_pkg::MAX_VAL;
    endcase
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he);
  endfunction

  stac_prescaler u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .clear(s_reg.psr),
    .taps(presc_taps)
  );

  // stored bit drives the prescaler reset
  assign presc_clear = s_reg.psr;
  assign mode = {s_reg.ctrl_b[4:3], s_reg.ctrl_a[1:0]};
  assign top_val = top_of(mode, s_reg.cmpa, s_reg.cap);
  // compare A as PWM top gives no channel A output
  assign a_is_top = is_pwm(mode) && (mode == 4'h9 || mode == 4'hb ||
    mode == 4'hf);

  // no tick while the clock source is none
  always_comb
  begin
    unique case (s_reg.ctrl_b[2:0])
      stac_pkg::CS_NONE: timer_tick = 1'b0;
      stac_pkg::CS_DIV1: timer_tick = 1'b1;
      stac_pkg::CS_DIV8: timer_tick = presc_taps[0];
      stac_pkg::CS_DIV64: timer_tick = presc_taps[1];
      stac_pkg::CS_DIV256: timer_tick = presc_taps[2];
      stac_pkg::CS_DIV1024: timer_tick = presc_taps[3];
      stac_pkg::CS_EXT_FALL: timer_tick = s_reg.ext_prev &&
        !s_reg.ext_sync[1];
      default: timer_tick = !s_reg.ext_prev && s_reg.ext_sync[1];
    endcase
  end

  assign match_a = (s_reg.cnt == s_reg.cmpa);
  assign match_b = (s_reg.cnt == s_reg.cmpb);
  assign at_bottom = (s_reg.cnt == stac_pkg::BOTTOM_VAL);
  assign at_max = (s_reg.cnt == stac_pkg::MAX_VAL);
  assign at_top = (s_reg.cnt == top_val);
  assign wrap = timer_tick && at_top;
  assign compare_output_a = is_pwm(mode) && !a_is_top &&
    (s_reg.cnt < s_reg.cmpa);
  assign compare_output_b = is_pwm(mode) && (s_reg.cnt < s_reg.cmpb);

  // filtered level moves only after agreeing samples
  assign cap_src = s_reg.ctrl_b[stac_pkg::CTRL_B_FILT] ?
    ((&s_reg.filt) ? 1'b1 : ((~|s_reg.filt) ? 1'b0 : s_reg.filt_lvl)) :
    (capture_src_cmp ? analog_cmp_out : s_reg.pin_sync[1]);
  assign filt_new = capture_src_cmp ? analog_cmp_out : s_reg.pin_sync[1];
  assign cap_event = (cap_src != s_reg.filt_lvl) &&
    (cap_src == s_reg.ctrl_b[stac_pkg::CTRL_B_EDGE]);

  // each flag gated by its own mask bit
  assign irq_overflow = s_reg.flags[stac_pkg::FLAG_OVF] &&
    s_reg.mask[stac_pkg::FLAG_OVF];
  assign irq_match_a = s_reg.flags[stac_pkg::FLAG_MA] &&
    s_reg.mask[stac_pkg::FLAG_MA];
  assign irq_match_b = s_reg.flags[stac_pkg::FLAG_MB] &&
    s_reg.mask[stac_pkg::FLAG_MB];
  assign irq_capture = s_reg.flags[stac_pkg::FLAG_CAP] &&
    s_reg.mask[stac_pkg::FLAG_CAP];
  assign io_rdata = s_reg.rdata;

  always_comb
  begin
    s_next = s_reg;
    s_next.pin_sync = {s_reg.pin_sync[0], capture_pin};
    s_next.ext_sync = {s_reg.ext_sync[0], external_count_pin};
    s_next.ext_prev = s_reg.ext_sync[1];
    s_next.filt = {s_reg.filt[stac_pkg::FILT_LEN-2:0], filt_new};
    s_next.filt_lvl = cap_src;
    // self-clearing after one cycle of reset
    s_next.psr = 1'b0;
    // Counting and top reload
    if (timer_tick)
    begin
      s_next.cnt = wrap ? stac_pkg::BOTTOM_VAL : s_reg.cnt + 16'h0001;
      if (wrap && is_pwm(mode))
      begin
        // buffered compare A and B values taken at the wrap
        s_next.cmpa = s_reg.cmpa_buf;
        s_next.cmpb = s_reg.cmpb_buf;
      end
    end
    if (!is_pwm(mode))
    begin
      s_next.cmpa = s_reg.cmpa_buf;
      s_next.cmpb = s_reg.cmpb_buf;
    end
    // Software clears flags by writing ones
    if (io_wr && io_addr == stac_pkg::ADDR_FLAGS)
      s_next.flags = s_reg.flags & ~io_wdata[3:0];
    s_next.rdata = stac_pkg::RST_BYTE;
    if (io_wr)
    begin
      unique case (io_addr)
        stac_pkg::ADDR_CTRL_A: s_next.ctrl_a = io_wdata;
        stac_pkg::ADDR_CTRL_B: s_next.ctrl_b = io_wdata;
        // high bytes land in the one holding register
        stac_pkg::ADDR_CNT_H, stac_pkg::ADDR_CMPA_H,
        stac_pkg::ADDR_CMPB_H, stac_pkg::ADDR_CAP_H: s_next.hold = io_wdata;
        // holding byte and low byte load together
        stac_pkg::ADDR_CNT_L: s_next.cnt = {s_reg.hold, io_wdata};
        stac_pkg::ADDR_CMPA_L: s_next.cmpa_buf = {s_reg.hold, io_wdata};
        stac_pkg::ADDR_CMPB_L: s_next.cmpb_buf = {s_reg.hold, io_wdata};
        stac_pkg::ADDR_CAP_L:
          if (cap_is_top(mode))
            s_next.cap = {s_reg.hold, io_wdata};
        stac_pkg::ADDR_MASK: s_next.mask = io_wdata[3:0];
        stac_pkg::ADDR_SFIO: s_next.psr = io_wdata[stac_pkg::PSR_BIT];
        default: ;
      endcase
    end
    else if (io_rd)
    begin
      unique case (io_addr)
        stac_pkg::ADDR_CTRL_A: s_next.rdata = s_reg.ctrl_a;
        stac_pkg::ADDR_CTRL_B: s_next.rdata = s_reg.ctrl_b;
        // low-byte read latches the high byte
        stac_pkg::ADDR_CNT_L:
        begin
          s_next.rdata = s_reg.cnt[7:0];
          s_next.hold = s_reg.cnt[15:8];
        end
        stac_pkg::ADDR_CAP_L:
        begin
          s_next.rdata = s_reg.cap[7:0];
          s_next.hold = s_reg.cap[15:8];
        end
        // counter and capture high-byte reads return the holding register
        stac_pkg::ADDR_CNT_H, stac_pkg::ADDR_CAP_H: s_next.rdata = s_reg.hold;
        stac_pkg::ADDR_CMPA_L: s_next.rdata = s_reg.cmpa_buf[7:0];
        stac_pkg::ADDR_CMPB_L: s_next.rdata = s_reg.cmpb_buf[7:0];
        stac_pkg::ADDR_CMPA_H: s_next.rdata = s_reg.cmpa_buf[15:8];
        stac_pkg::ADDR_CMPB_H: s_next.rdata = s_reg.cmpb_buf[15:8];
        stac_pkg::ADDR_FLAGS: s_next.rdata = {4'h0, s_reg.flags};
        stac_pkg::ADDR_MASK: s_next.rdata = {4'h0, s_reg.mask};
        default: s_next.rdata = stac_pkg::RST_BYTE;
      endcase
    end
    // capture flag in the same cycle
    if (cap_event)
    begin
      s_next.cap = s_reg.cnt;
      s_next.flags[stac_pkg::FLAG_CAP] = 1'b1;
    end
    if (timer_tick && match_a)
      s_next.flags[stac_pkg::FLAG_MA] = 1'b1;
    if (timer_tick && match_b)
      s_next.flags[stac_pkg::FLAG_MB] = 1'b1;
    if (wrap)
      s_next.flags[stac_pkg::FLAG_OVF] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.cnt <= stac_pkg::RST_WORD;
      s_reg.flags <= stac_pkg::RST_NIB;
      s_reg.mask <= stac_pkg::RST_NIB;
    end
    else
      s_reg <= s_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // bit set for one cycle then cleared
  a_psr_self_clear: assert property (
    io_wr && io_addr == stac_pkg::ADDR_SFIO && io_wdata[0]
    |=> s_reg.psr ##1 !s_reg.psr) else $error("prescaler bit stuck");
  // zero write has no effect, reads zero
  a_psr_zero_write: assert property (
    io_wr && io_addr == stac_pkg::ADDR_SFIO && !io_wdata[0]
    |=> !presc_clear) else $error("zero write reset prescaler");
  a_psr_reads_zero: assert property (
    io_rd && !io_wr && io_addr == stac_pkg::ADDR_SFIO
    |=> io_rdata == 8'h00) else $error("prescaler bit read nonzero");
  a_stop_holds: assert property (
    s_reg.ctrl_b[2:0] == stac_pkg::CS_NONE &&
    !(io_wr && io_addr == stac_pkg::ADDR_CNT_L)
    |=> s_reg.cnt == $past(s_reg.cnt)) else $error("counter moved");
  a_low_write_load: assert property (
    io_wr && io_addr == stac_pkg::ADDR_CNT_L
    |=> s_reg.cnt == {$past(s_reg.hold), $past(io_wdata)})
    else $error("counter load wrong");
  // low read fills the holding register, high read returns it
  a_low_read_hold: assert property (
    io_rd && !io_wr && io_addr == stac_pkg::ADDR_CNT_L ##1 !io_rd && !io_wr ##1
    io_rd && !io_wr && io_addr == stac_pkg::ADDR_CNT_H
    |=> io_rdata == $past(s_reg.cnt[15:8], 3)) else $error("pair wrong");
  // compare high read leaves holding register alone
  a_cmp_high_direct: assert property (
    io_rd && !io_wr && io_addr == stac_pkg::ADDR_CMPA_H
    |=> io_rdata == $past(s_reg.cmpa_buf[15:8]) &&
    s_reg.hold == $past(s_reg.hold)) else $error("compare read wrong");
  // flag and capture in one cycle
  a_capture_flag: assert property (
    cap_event |=> s_reg.cap == $past(s_reg.cnt) &&
    s_reg.flags[stac_pkg::FLAG_CAP]) else $error("capture flag late");
  // set wins over a clear in the same cycle
  a_match_set_wins: assert property (
    timer_tick && match_a |=> s_reg.flags[stac_pkg::FLAG_MA])
    else $error("match flag lost");
  // no PWM on channel A when it is the top
  a_top_no_pwm: assert property (
    (mode == 4'h9 || mode == 4'hb || mode == 4'hf) |-> !compare_output_a)
    else $error("channel A driven");

  c_capture: cover property (cap_event);
  c_overflow: cover property (wrap);
  c_presc_reset: cover property (presc_clear ##1 !presc_clear);
  c_word_write: cover property (io_wr && io_addr == stac_pkg::ADDR_CNT_H
    ##1 io_wr && io_addr == stac_pkg::ADDR_CNT_L);
endmodule

//--- stac_pkg.sv
// Constants for the sixteen-bit timer access core
package stac_pkg;
  // Register addresses on the 8-bit I/O bus
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_CNT_L = 4'h2;
  localparam logic [3:0] ADDR_CNT_H = 4'h3;
  localparam logic [3:0] ADDR_CMPA_L = 4'h4;
  localparam logic [3:0] ADDR_CMPA_H = 4'h5;
  localparam logic [3:0] ADDR_CMPB_L = 4'h6;
  localparam logic [3:0] ADDR_CMPB_H = 4'h7;
  localparam logic [3:0] ADDR_CAP_L = 4'h8;
  localparam logic [3:0] ADDR_CAP_H = 4'h9;
  localparam logic [3:0] ADDR_FLAGS = 4'ha;
  localparam logic [3:0] ADDR_MASK = 4'hb;
  localparam logic [3:0] ADDR_SFIO = 4'hc;
  // Bit positions
  localparam int PSR_BIT = 0;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MB = 1;
  localparam int FLAG_MA = 2;
  localparam int FLAG_CAP = 3;
  localparam int CTRL_B_EDGE = 6;
  localparam int CTRL_B_FILT = 7;
  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_NIB = 4'h0;
  // Counter landmarks
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  // Clock select codes
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  // Prescaler counter width and noise filter length in samples
  localparam int PRESC_W = 10;
  localparam int FILT_LEN = 4;
  localparam logic [PRESC_W-1:0] PRESC_RST = 10'h000;
endpackage

//--- stac_prescaler.sv
// Free running prescaler shared by both timers
`timescale 1ns/10ps
module stac_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  // Tick enables: divide by 8, 64, 256, 1024
  output logic [3:0] taps
);
  typedef struct packed {
    logic [stac_pkg::PRESC_W-1:0] count;
  } stac_presc_state_t;

  stac_presc_state_t s_reg;
  stac_presc_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (clear)
      s_next.count = stac_pkg::PRESC_RST;
    else
      s_next.count = s_reg.count + 10'h001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_reg.count <= stac_pkg::PRESC_RST;
    else
      s_reg <= s_next;
  end

  assign taps[0] = (&s_reg.count[2:0]) && !clear;
  assign taps[1] = (&s_reg.count[5:0]) && !clear;
  assign taps[2] = (&s_reg.count[7:0]) && !clear;
  assign taps[3] = (&s_reg.count[9:0]) && !clear;
endmodule

//--- stac_cpu_model.sv
// CPU side model driving the timer's byte-wide register bus
`timescale 1ns/10ps
module stac_cpu_model (
  // Clock
  input wire logic clk,
  // Register bus
  output logic [3:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial
  begin
    io_addr = 4'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  // high byte first, pair never split
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  // low byte first, pair never split
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask
endmodule

//--- tb_sixteen_bit_timer_access_core.sv
// Self-checking testbench for the sixteen-bit timer access core
`timescale 1ns/10ps
module tb_sixteen_bit_timer_access_core;
  logic clk;
  logic rst_n;
  logic [3:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic ext_pin;
  logic cap_pin;
  logic cmp_out;
  logic src_cmp;
  logic [3:0] taps;
  logic pclr;
  logic irq_ovf, irq_ma, irq_mb, irq_cap;
  logic tick, m_a, m_b, at_bot, at_max, at_top, oc_a, oc_b;
  int n_errors;
  int comparisons;

  stac_timer dut_u (.clk(clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .external_count_pin(ext_pin), .capture_pin(cap_pin),
    .analog_cmp_out(cmp_out), .capture_src_cmp(src_cmp),
    .presc_taps(taps), .presc_clear(pclr), .irq_overflow(irq_ovf),
    .irq_match_a(irq_ma), .irq_match_b(irq_mb), .irq_capture(irq_cap),
    .timer_tick(tick), .match_a(m_a), .match_b(m_b), .at_bottom(at_bot),
    .at_max(at_max), .at_top(at_top), .compare_output_a(oc_a),
    .compare_output_b(oc_b));
  stac_cpu_model cpu_u (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));

  always #5 clk = ~clk;

  task automatic close_out();
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    for (int i = 0; i < 16; i++)
    begin
      cpu_u.rd(i[3:0], d);
      chk({8'h00, d}, 16'h0000);
    end
  endtask
  task automatic t_regs();
    logic [7:0] d;
    cpu_u.wr(stac_pkg::ADDR_MASK, 8'h0f);
    cpu_u.rd(stac_pkg::ADDR_MASK, d);
    chk({8'h00, d}, 16'h000f);
    cpu_u.wr(stac_pkg::ADDR_CTRL_A, 8'h01);
    cpu_u.rd(stac_pkg::ADDR_CTRL_A, d);
    chk({8'h00, d}, 16'h0001);
    cpu_u.wr(stac_pkg::ADDR_CTRL_A, 8'h00);
    cpu_u.wr(4'hf, 8'h5a);
    cpu_u.rd(4'hf, d);
    chk({8'h00, d}, 16'h0000);
  endtask
  task automatic t_hold();
    logic [15:0] v;
    logic [7:0] d;
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h01ff);
    cpu_u.rd16(stac_pkg::ADDR_CNT_L, v);
    chk(v, 16'h01ff);
    cycles(5);
    cpu_u.rd16(stac_pkg::ADDR_CNT_L, v);
    chk(v, 16'h01ff);
    cpu_u.rd(stac_pkg::ADDR_CAP_L, d);
    cpu_u.rd(stac_pkg::ADDR_CNT_H, d);
    chk({8'h00, d}, 16'h0000);
  endtask
  task automatic t_cmp();
    logic [15:0] v;
    logic [7:0] d;
    cpu_u.wr16(stac_pkg::ADDR_CMPA_L, 16'h1234);
    cpu_u.wr(stac_pkg::ADDR_CNT_H, 8'h56);
    cpu_u.rd(stac_pkg::ADDR_CMPA_H, d);
    chk({8'h00, d}, 16'h0012);
    cpu_u.rd(stac_pkg::ADDR_CNT_H, d);
    chk({8'h00, d}, 16'h0056);
    cpu_u.rd16(stac_pkg::ADDR_CMPA_L, v);
    chk(v, 16'h1234);
  endtask
  task automatic t_presc();
    int n;
    logic [7:0] d;
    n = 0;
    cpu_u.wr(stac_pkg::ADDR_SFIO, 8'h01);
    repeat (4)
    begin
      if (pclr === 1'b1)
        n++;
      cycles(1);
    end
    chk(n[15:0], 16'h0001);
    n = 0;
    repeat (16)
    begin
      if (taps[0] === 1'b1)
        n++;
      cycles(1);
    end
    chk(n[15:0], 16'h0002);
    cpu_u.rd(stac_pkg::ADDR_SFIO, d);
    chk({8'h00, d}, 16'h0000);
    n = 0;
    cpu_u.wr(stac_pkg::ADDR_SFIO, 8'h00);
    repeat (4)
    begin
      if (pclr === 1'b1)
        n++;
      cycles(1);
    end
    chk(n[15:0], 16'h0000);
  endtask
  task automatic t_match();
    logic [15:0] v, w;
    logic [7:0] d;
    int k;
    cpu_u.wr16(stac_pkg::ADDR_CMPA_L, 16'h0005);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0000);
    cpu_u.wr(stac_pkg::ADDR_MASK, 8'h04);
    cpu_u.wr(stac_pkg::ADDR_FLAGS, 8'h0f);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h01);
    k = 0;
    while (m_a !== 1'b1 && k < 100)
    begin
      cycles(1);
      k++;
    end
    chk_bit(m_a, 1'b1);
    cycles(2);
    cpu_u.rd(stac_pkg::ADDR_FLAGS, d);
    chk_bit(d[stac_pkg::FLAG_MA], 1'b1);
    chk_bit(irq_ma, 1'b1);
    chk_bit(irq_mb, 1'b0);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h00);
    cpu_u.wr(stac_pkg::ADDR_FLAGS, 8'h04);
    cycles(1);
    chk_bit(irq_ma, 1'b0);
    cpu_u.rd16(stac_pkg::ADDR_CNT_L, v);
    cycles(6);
    cpu_u.rd16(stac_pkg::ADDR_CNT_L, w);
    chk(w, v);
  endtask
  task automatic t_edges();
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'hffff);
    chk_bit(at_max, 1'b1);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0000);
    chk_bit(at_bot, 1'b1);
    chk_bit(at_max, 1'b0);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0005);
    chk_bit(m_a, 1'b1);
    chk_bit(at_bot, 1'b0);
    cpu_u.wr(stac_pkg::ADDR_CTRL_A, 8'h01);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h00ff);
    chk_bit(at_top, 1'b1);
    cpu_u.wr(stac_pkg::ADDR_CTRL_A, 8'h00);
    cycles(1);
    chk_bit(at_top, 1'b0);
  endtask
  task automatic t_cap();
    logic [15:0] v;
    logic [7:0] d;
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0abc);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h40);
    cpu_u.wr(stac_pkg::ADDR_FLAGS, 8'h08);
    cmp_out = 1'b1;
    cycles(4);
    cpu_u.rd(stac_pkg::ADDR_FLAGS, d);
    chk_bit(d[stac_pkg::FLAG_CAP], 1'b1);
    cpu_u.rd16(stac_pkg::ADDR_CAP_L, v);
    chk(v, 16'h0abc);
    cmp_out = 1'b0;
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'hc0);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0123);
    cycles(8);
    cpu_u.wr(stac_pkg::ADDR_FLAGS, 8'h08);
    cmp_out = 1'b1;
    cycles(1);
    cmp_out = 1'b0;
    cycles(10);
    cpu_u.rd(stac_pkg::ADDR_FLAGS, d);
    chk_bit(d[stac_pkg::FLAG_CAP], 1'b0);
    cmp_out = 1'b1;
    cycles(12);
    cpu_u.rd(stac_pkg::ADDR_FLAGS, d);
    chk_bit(d[stac_pkg::FLAG_CAP], 1'b1);
    cpu_u.rd16(stac_pkg::ADDR_CAP_L, v);
    chk(v, 16'h0123);
  endtask
  task automatic t_run();
    logic [7:0] d;
    cpu_u.wr(stac_pkg::ADDR_MASK, 8'h09);
    chk_bit(irq_cap, 1'b1);
    cpu_u.wr(stac_pkg::ADDR_FLAGS, 8'h0f);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h01);
    chk_bit(tick, 1'b1);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'hffff);
    chk_bit(at_max, 1'b1);
    cycles(1);
    chk_bit(at_bot, 1'b1);
    chk_bit(m_b, 1'b1);
    chk_bit(irq_ovf, 1'b1);
    chk_bit(irq_cap, 1'b0);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h00);
    cpu_u.rd(stac_pkg::ADDR_FLAGS, d);
    chk({8'h00, d}, 16'h0003);
    cpu_u.wr(stac_pkg::ADDR_FLAGS, 8'h0f);
  endtask
  task automatic t_pwm();
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0000);
    cpu_u.wr16(stac_pkg::ADDR_CMPB_L, 16'h0003);
    cpu_u.wr(stac_pkg::ADDR_CTRL_A, 8'h03);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h18);
    chk_bit(oc_a, 1'b0);
    chk_bit(oc_b, 1'b1);
    cpu_u.wr16(stac_pkg::ADDR_CMPA_L, 16'h0008);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0005);
    chk_bit(at_top, 1'b1);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h19);
    cycles(1);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h18);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0008);
    chk_bit(at_top, 1'b1);
    chk_bit(oc_a, 1'b0);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h08);
    cpu_u.wr(stac_pkg::ADDR_CTRL_A, 8'h01);
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0000);
    chk_bit(oc_a, 1'b1);
    cpu_u.wr(stac_pkg::ADDR_CTRL_A, 8'h00);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h00);
  endtask
  task automatic t_ext();
    logic [15:0] v;
    cap_pin = 1'b1;
    cycles(3);
    src_cmp = 1'b0;
    cpu_u.wr16(stac_pkg::ADDR_CNT_L, 16'h0000);
    cpu_u.wr(stac_pkg::ADDR_FLAGS, 8'h08);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h07);
    repeat (3)
    begin
      ext_pin = 1'b1;
      cycles(2);
      ext_pin = 1'b0;
      cycles(2);
    end
    cycles(4);
    cap_pin = 1'b0;
    cycles(4);
    chk_bit(irq_cap, 1'b1);
    cpu_u.wr(stac_pkg::ADDR_CTRL_B, 8'h00);
    cpu_u.rd16(stac_pkg::ADDR_CAP_L, v);
    chk(v, 16'h0003);
    cpu_u.rd16(stac_pkg::ADDR_CNT_L, v);
    chk(v, 16'h0003);
  endtask

  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    cmp_out = 1'b0;
    src_cmp = 1'b1;
    n_errors = 0;
    comparisons = 0;
    cycles(16);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_hold();
    t_cmp();
    t_presc();
    t_match();
    t_edges();
    t_cap();
    t_run();
    t_pwm();
    t_ext();
    close_out();
  end
endmodule
